// *** hw/rx_port_monitor_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// R1: Port-select register steers per-port register access.
// R2: Low byte of latest line length readable.
// R3: Length frozen until read when enable set.
// R4: High-byte read latches matching low byte.
// R5: Capture frequency only beyond hysteresis band.
// R6: Stable after in-band time per select code.
// R7: Below low limit sets no-link-clock flag.
// R8: Two scratch bytes, plain storage, reset 00/01.
// R9: Length mismatch sets status bit 3.
// R10: Checksum failure sets status bit 2.
// R11: Multi-bit header error sets bit 1.
// R12: Single-bit header error sets bit 0.
// R13: Flags sticky, cleared on status read.
// R14: High byte completes 16-bit line length.
// R15: Error in clearing read cycle survives.
module rx_port_monitor_regs
    import rx_port_monitor_pkg::*;
#(
    parameter int STABLE_C2 = (STABLE_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int STABLE_C3 = (STABLE_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register access from the serial control front end
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Per-port receiver measurements
    input wire logic [NUM_PORTS-1:0] line_done_i,
    input wire logic [NUM_PORTS*16-1:0] line_length_i,
    input wire logic [NUM_PORTS-1:0] line_length_change_irq_enable_i,
    input wire logic [NUM_PORTS-1:0] freq_valid_i,
    input wire logic [NUM_PORTS*8-1:0] freq_mhz_i,
    // Per-port packet error pulses
    input wire logic [NUM_PORTS-1:0] length_error_i,
    input wire logic [NUM_PORTS-1:0] payload_checksum_error_i,
    input wire logic [NUM_PORTS-1:0] header_multibit_error_i,
    input wire logic [NUM_PORTS-1:0] header_singlebit_error_i,
    // Per-port detector status
    output logic [NUM_PORTS-1:0] no_link_clock_flag_o,
    output logic [NUM_PORTS-1:0] freq_stable_o,
    output logic [NUM_PORTS*8-1:0] freq_captured_o
);

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] port_sel;
        logic [NUM_PORTS-1:0][15:0] length;
        logic [NUM_PORTS-1:0] frozen;
        logic [NUM_PORTS-1:0][7:0] low_latch;
        logic [NUM_PORTS-1:0] low_latched;
        logic [NUM_PORTS-1:0][7:0] ctl;
        logic [NUM_PORTS-1:0][7:0] scratch0;
        logic [NUM_PORTS-1:0][7:0] scratch1;
        logic [NUM_PORTS-1:0][ERR_BITS-1:0] err;
        logic [NUM_PORTS-1:0][7:0] freq;
        logic [NUM_PORTS-1:0][STABLE_CNT_W-1:0] stable_cnt;
        logic [NUM_PORTS-1:0] stable;
        logic [NUM_PORTS-1:0] no_clk;
    } state_t;

    state_t s;
    state_t next_s;

    // Stability count for a select code
    function automatic logic [STABLE_CNT_W-1:0] stable_limit(
        input logic [1:0] code);
        case (code)
            2'h0: stable_limit = STABLE_CNT_W'(STABLE_C0);
            2'h1: stable_limit = STABLE_CNT_W'(STABLE_C1);
            2'h2: stable_limit = STABLE_CNT_W'(STABLE_C2);
            default: stable_limit = STABLE_CNT_W'(STABLE_C3);
        endcase
    endfunction

    // Absolute difference of two frequencies
    function automatic logic [7:0] abs_diff(input logic [7:0] a,
        input logic [7:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    logic [1:0] sel;
    assign sel = s.port_sel[1:0]; // Selects which port bank is seen [R1]

    always_comb begin
        logic [7:0] meas;
        logic [ERR_BITS-1:0] ev;
        logic sts_rd;
        meas = 8'h00;
        ev = '0;
        sts_rd = 1'b0;
        next_s = s;
        // Per-port measurement and flag logic
        for (int p = 0; p < NUM_PORTS; p++) begin
            // New line length unless frozen awaiting a read
            if (line_done_i[p] && !s.frozen[p]) begin
                next_s.length[p] = line_length_i[p*16 +: 16]; // [R2] [R14]
                next_s.frozen[p] = line_length_change_irq_enable_i[p]; // [R3]
            end
            if (!line_length_change_irq_enable_i[p]) begin
                next_s.frozen[p] = 1'b0;
            end
            // Frequency capture with hysteresis
            meas = freq_mhz_i[p*8 +: 8];
            if (freq_valid_i[p]) begin
                next_s.no_clk[p] = meas <
                    {4'h0, s.ctl[p][LOW_MSB:LOW_LSB]}; // [R7]
                if (abs_diff(meas, s.freq[p]) >
                    {6'h00, s.ctl[p][HYST_MSB:HYST_LSB]}) begin
                    next_s.freq[p] = meas; // [R5]
                    next_s.stable_cnt[p] = '0;
                    next_s.stable[p] = 1'b0;
                end else if (s.stable_cnt[p] <
                    stable_limit(s.ctl[p][STABLE_MSB:STABLE_LSB])) begin
                    next_s.stable_cnt[p] = s.stable_cnt[p] + 1'b1;
                end else begin
                    next_s.stable[p] = 1'b1; // [R6]
                end
            end
        end
        // Register read path; a read of the status clears it
        next_s.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == PORT_SELECT_ADDR) begin
                next_s.rdata = s.port_sel;
            end else if (reg_addr_i == LINE_LENGTH_HIGH_ADDR) begin
                next_s.rdata = s.length[sel][15:8];
                next_s.low_latch[sel] = s.length[sel][7:0]; // [R4]
                next_s.low_latched[sel] = 1'b1;
            end else if (reg_addr_i == LINE_LENGTH_LOW_ADDR) begin
                next_s.rdata = s.low_latched[sel] ? s.low_latch[sel]
                    : s.length[sel][7:0]; // [R4]
                next_s.low_latched[sel] = 1'b0;
                next_s.frozen[sel] = 1'b0; // Read releases freeze [R3]
            end else if (reg_addr_i == FREQ_DETECT_CONTROL_ADDR) begin
                next_s.rdata = s.ctl[sel];
            end else if (reg_addr_i == MESSAGE_SCRATCH_0_ADDR) begin
                next_s.rdata = s.scratch0[sel]; // [R8]
            end else if (reg_addr_i == MESSAGE_SCRATCH_1_ADDR) begin
                next_s.rdata = s.scratch1[sel]; // [R8]
            end else if (reg_addr_i == PACKET_ERROR_STATUS_ADDR) begin
                next_s.rdata = {4'h0, s.err[sel]}; // [R13]
                sts_rd = 1'b1;
            end
        end
        // Register write path, ignored on read-only addresses
        if (reg_wr_i) begin
            if (reg_addr_i == PORT_SELECT_ADDR) begin
                next_s.port_sel = reg_wdata_i;
            end else if (reg_addr_i == FREQ_DETECT_CONTROL_ADDR) begin
                next_s.ctl[sel] = reg_wdata_i;
            end else if (reg_addr_i == MESSAGE_SCRATCH_0_ADDR) begin
                next_s.scratch0[sel] = reg_wdata_i; // [R8]
            end else if (reg_addr_i == MESSAGE_SCRATCH_1_ADDR) begin
                next_s.scratch1[sel] = reg_wdata_i; // [R8]
            end
        end
        // Sticky flags; a set in the clearing cycle wins
        for (int p = 0; p < NUM_PORTS; p++) begin
            ev = '0;
            ev[LEN_ERR_BIT] = length_error_i[p]; // [R9]
            ev[PAYLOAD_CHECKSUM_FLAG_BIT] = payload_checksum_error_i[p]; // [R10]
            ev[MULTI_ERR_BIT] = header_multibit_error_i[p]; // [R11]
            ev[SINGLE_ERR_BIT] = header_singlebit_error_i[p]; // [R12]
            if (sts_rd && (sel == 2'(p))) begin
                next_s.err[p] = ev; // [R13] [R15]
            end else begin
                next_s.err[p] = s.err[p] | ev; // [R13]
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.port_sel <= PORT_SELECT_RST;
            for (int p = 0; p < NUM_PORTS; p++) begin
                s.ctl[p] <= FREQ_DETECT_CONTROL_RST;
                s.scratch0[p] <= MESSAGE_SCRATCH_0_RST;
                s.scratch1[p] <= MESSAGE_SCRATCH_1_RST;
            end
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign reg_rdata_o = s.rdata;
    assign no_link_clock_flag_o = s.no_clk;
    assign freq_stable_o = s.stable;
    assign freq_captured_o = s.freq;

    // Checks
    // Status read of port 3 landing on a multi-bit error pulse
    sequence clear_hit_s;
        reg_rd_i && reg_addr_i == PACKET_ERROR_STATUS_ADDR && sel == 2'h3
            && header_multibit_error_i[3];
    endsequence

    // Write strobe to the port select register
    sequence sel_write_s;
        reg_wr_i && reg_addr_i == PORT_SELECT_ADDR;
    endsequence

    // High-byte read of port 0, first step of a 16-bit read
    sequence high_read_s;
        reg_rd_i && reg_addr_i == LINE_LENGTH_HIGH_ADDR && sel == 2'h0;
    endsequence

    // In-band sample on port 2, must not move the captured value
    sequence in_band_s;
        freq_valid_i[2] && abs_diff(freq_mhz_i[23:16], s.freq[2])
            <= {6'h00, s.ctl[2][HYST_MSB:HYST_LSB]};
    endsequence

    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (length_error_i[0] && !(reg_rd_i &&
        reg_addr_i == PACKET_ERROR_STATUS_ADDR && sel == 2'h0))
        |=> s.err[0][LEN_ERR_BIT]) // [R9]
        else $error("length flag not set");
    cksum_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        payload_checksum_error_i[1] |=> s.err[1][PAYLOAD_CHECKSUM_FLAG_BIT]) // [R10]
        else $error("checksum flag not set");
    multi_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        header_multibit_error_i[2] |=> s.err[2][MULTI_ERR_BIT]) // [R11]
        else $error("multibit flag not set");
    single_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        header_singlebit_error_i[3] |=> s.err[3][SINGLE_ERR_BIT]) // [R12]
        else $error("singlebit flag not set");
    status_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (reg_rd_i && reg_addr_i == PACKET_ERROR_STATUS_ADDR && sel == 2'h0
        && !length_error_i[0]) |=> !s.err[0][LEN_ERR_BIT]) // [R13]
        else $error("status not cleared");
    status_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (reg_rd_i && reg_addr_i == PACKET_ERROR_STATUS_ADDR)
        |=> reg_rdata_o[7:4] == 4'h0) // [R13]
        else $error("reserved bits nonzero");
    freeze_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (s.frozen[0] && line_length_change_irq_enable_i[0]
        && !(reg_rd_i && sel == 2'h0)) |=> $stable(s.length[0])) // [R3]
        else $error("frozen length changed");
    scratch_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == MESSAGE_SCRATCH_0_ADDR && sel == 2'h2)
        |=> s.scratch0[2] == $past(reg_wdata_i)) // [R8]
        else $error("scratch write lost");
    low_clock_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (freq_valid_i[2] && freq_mhz_i[23:16] <
        {4'h0, s.ctl[2][LOW_MSB:LOW_LSB]}) |=> no_link_clock_flag_o[2]) // [R7]
        else $error("no clock flag missing");
    survive_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        clear_hit_s |=> s.err[3][MULTI_ERR_BIT]) // [R15]
        else $error("error lost on clearing read");
    port_select_a: assert property (@(posedge clk_i) // [R1]
        disable iff (!nrst_i)
        sel_write_s |=> s.port_sel == $past(reg_wdata_i))
        else $error("port select write lost");
    line_capture_a: assert property (@(posedge clk_i) // [R2] [R14]
        disable iff (!nrst_i)
        (line_done_i[0] && !s.frozen[0])
        |=> s.length[0] == $past(line_length_i[15:0]))
        else $error("line length not captured");
    low_latch_a: assert property (@(posedge clk_i) // [R4]
        disable iff (!nrst_i)
        high_read_s |=> s.low_latched[0]
        && s.low_latch[0] == $past(s.length[0][7:0]))
        else $error("low byte not latched");
    hyst_hold_a: assert property (@(posedge clk_i) // [R5]
        disable iff (!nrst_i)
        in_band_s |=> $stable(s.freq[2]))
        else $error("in-band sample captured");
    ctl_write_a: assert property (@(posedge clk_i) // [R5]
        disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == FREQ_DETECT_CONTROL_ADDR && sel == 2'h2)
        |=> s.ctl[2] == $past(reg_wdata_i))
        else $error("detector control write lost");
    // Stable may only rise once the in-band count reached its limit
    stable_set_a: assert property (@(posedge clk_i) // [R6]
        disable iff (!nrst_i)
        $rose(s.stable[2]) |-> $past(s.stable_cnt[2])
        == stable_limit($past(s.ctl[2][STABLE_MSB:STABLE_LSB])))
        else $error("stable raised early");
    mailbox_hold_a: assert property (@(posedge clk_i) // [R8]
        disable iff (!nrst_i)
        !(reg_wr_i && reg_addr_i == MESSAGE_SCRATCH_1_ADDR && sel == 2'h2)
        |=> $stable(s.scratch1[2]))
        else $error("mailbox changed without write");

    // Flags of every port hold until a status read of that port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sticky
        sticky_hold_a: assert property (@(posedge clk_i) // [R13]
            disable iff (!nrst_i)
            !(reg_rd_i && reg_addr_i == PACKET_ERROR_STATUS_ADDR
            && sel == 2'(p)) |=> (s.err[p] & $past(s.err[p]))
            == $past(s.err[p]))
            else $error("flag dropped without read");
    end

endmodule // rx_port_monitor_regs

// *** hw/rx_port_monitor_pkg.sv ***
package rx_port_monitor_pkg;
    // Port count and register map
    localparam int NUM_PORTS = 4;
    localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
    localparam logic [7:0] LINE_LENGTH_HIGH_ADDR = 8'h75;
    localparam logic [7:0] LINE_LENGTH_LOW_ADDR = 8'h76;
    localparam logic [7:0] FREQ_DETECT_CONTROL_ADDR = 8'h77;
    localparam logic [7:0] MESSAGE_SCRATCH_0_ADDR = 8'h78;
    localparam logic [7:0] MESSAGE_SCRATCH_1_ADDR = 8'h79;
    localparam logic [7:0] PACKET_ERROR_STATUS_ADDR = 8'h7A;
    // Reset values
    localparam logic [7:0] FREQ_DETECT_CONTROL_RST = 8'hC5;
    localparam logic [7:0] MESSAGE_SCRATCH_0_RST = 8'h00;
    localparam logic [7:0] MESSAGE_SCRATCH_1_RST = 8'h01;
    localparam logic [7:0] PORT_SELECT_RST = 8'h00;
    // Field positions of the detector control
    localparam int HYST_MSB = 7;
    localparam int HYST_LSB = 6;
    localparam int STABLE_MSB = 5;
    localparam int STABLE_LSB = 4;
    localparam int LOW_MSB = 3;
    localparam int LOW_LSB = 0;
    // Error status bits; upper nibble reads zero
    localparam int LEN_ERR_BIT = 3;
    localparam int PAYLOAD_CHECKSUM_FLAG_BIT = 2;
    localparam int MULTI_ERR_BIT = 1;
    localparam int SINGLE_ERR_BIT = 0;
    localparam int ERR_BITS = 4;
    // Stability times in ns and cycle counts at 50 MHz
    localparam int CLK_PERIOD_NS = 20;
    localparam int STABLE_T0_NS = 40000;
    localparam int STABLE_T1_NS = 80000;
    localparam int STABLE_T2_NS = 320000;
    localparam int STABLE_T3_NS = 1280000;
    localparam int STABLE_C0 = (STABLE_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABLE_C1 = (STABLE_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABLE_CNT_W = 17;
endpackage

// *** dv/rx_link_source.sv ***
`timescale 1ns/100ps
module rx_link_source
    import rx_port_monitor_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Measurements and error pulses, error kind k of port p at 4k+p
    output logic [NUM_PORTS-1:0] line_done_o,
    output logic [NUM_PORTS*16-1:0] line_length_o,
    output logic [NUM_PORTS-1:0] freq_valid_o,
    output logic [NUM_PORTS*8-1:0] freq_mhz_o,
    output logic [4*NUM_PORTS-1:0] err_o
);
    // Idle state; data lines invert after each pulse so stale is not kept
    initial begin
        line_done_o = '0;
        line_length_o = '0;
        freq_valid_o = '0;
        freq_mhz_o = '0;
        err_o = '0;
    end
    // One received line
    task automatic line(input int p, input logic [15:0] len);
        @(negedge clk_i);
        line_length_o[16*p +: 16] = len;
        line_done_o[p] = 1'b1;
        @(negedge clk_i);
        line_done_o[p] = 1'b0;
        line_length_o[16*p +: 16] = ~len;
    endtask
    // One frequency sample in MHz
    task automatic freq(input int p, input logic [7:0] mhz);
        @(negedge clk_i);
        freq_mhz_o[8*p +: 8] = mhz;
        freq_valid_o[p] = 1'b1;
        @(negedge clk_i);
        freq_valid_o[p] = 1'b0;
        freq_mhz_o[8*p +: 8] = ~mhz;
    endtask
    // Packet errors, mask bit k is status bit k
    task automatic err(input int p, input logic [3:0] mask);
        @(negedge clk_i);
        for (int k = 0; k < 4; k++) err_o[4*k+p] = mask[k];
        @(negedge clk_i);
        err_o = '0;
    endtask
endmodule // rx_link_source

// *** dv/rx_port_monitor_regs_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module rx_port_monitor_regs_tb;
    import rx_port_monitor_pkg::*;
    logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [NUM_PORTS-1:0] irq_en = '0, done, fval, nclk, stable;
    logic [NUM_PORTS*16-1:0] len;
    logic [NUM_PORTS*8-1:0] freq, capt;
    logic [4*NUM_PORTS-1:0] err;
    int error_cnt = 0, n_tests = 0;
    // Short stability counts keep the run brief
    rx_port_monitor_regs #(.STABLE_C2(20), .STABLE_C3(40)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .line_done_i(done), .line_length_i(len),
        .line_length_change_irq_enable_i(irq_en), .freq_valid_i(fval),
        .freq_mhz_i(freq), .length_error_i(err[15:12]),
        .payload_checksum_error_i(err[11:8]),
        .header_multibit_error_i(err[7:4]),
        .header_singlebit_error_i(err[3:0]), .no_link_clock_flag_o(nclk),
        .freq_stable_o(stable), .freq_captured_o(capt));
    rx_link_source src (.clk_i(clk_i), .line_done_o(done),
        .line_length_o(len), .freq_valid_o(fval), .freq_mhz_o(freq),
        .err_o(err));
    // Clock
    initial forever #10 clk_i = ~clk_i;
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Register strobes, one cycle each, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        `CHK(reg_rdata_o, e)
    endtask
    task automatic t_reset;
        logic [15:0] tbl [8] = '{16'h4C00, 16'h77C5, 16'h7800, 16'h7901,
            16'h7A00, 16'h7500, 16'h7600, 16'h9000};
        foreach (tbl[i]) rd_chk(tbl[i][15:8], tbl[i][7:0]);
    endtask
    task automatic t_scratch;
        wr(8'h4C, 8'h02);
        wr(8'h78, 8'hA5);
        wr(8'h79, 8'h5A);
        wr(8'h7A, 8'hFF);
        rd_chk(8'h78, 8'hA5);
        rd_chk(8'h79, 8'h5A);
        rd_chk(8'h7A, 8'h00);
        wr(8'h4C, 8'h00);
        rd_chk(8'h78, 8'h00);
        rd_chk(8'h79, 8'h01);
    endtask
    // Sticky flags per port, read clears, error during read survives
    task automatic t_errors;
        wr(8'h4C, 8'h01);
        src.err(1, 4'b1001);
        src.err(3, 4'b0110);
        src.err(1, 4'b1000);
        rd_chk(8'h7A, 8'h09);
        rd_chk(8'h7A, 8'h00);
        wr(8'h4C, 8'h03);
        rd_chk(8'h7A, 8'h06);
        fork
            src.err(3, 4'b0010);
            rd_chk(8'h7A, 8'h00);
        join
        rd_chk(8'h7A, 8'h02);
        src.err(0, 4'b1000);
        src.err(1, 4'b0100);
        src.err(2, 4'b0010);
        src.err(3, 4'b0001);
        rd_chk(8'h7A, 8'h01);
        wr(8'h4C, 8'h02);
        rd_chk(8'h7A, 8'h02);
        wr(8'h4C, 8'h01);
        rd_chk(8'h7A, 8'h04);
        wr(8'h4C, 8'h00);
        rd_chk(8'h7A, 8'h08);
    endtask
    // Latched low byte, then freeze until read
    task automatic t_line;
        wr(8'h4C, 8'h00);
        src.line(0, 16'h1234);
        rd_chk(8'h75, 8'h12);
        src.line(0, 16'h5678);
        rd_chk(8'h76, 8'h34);
        rd_chk(8'h75, 8'h56);
        rd_chk(8'h76, 8'h78);
        irq_en[0] = 1'b1;
        src.line(0, 16'hABCD);
        src.line(0, 16'h1111);
        rd_chk(8'h75, 8'hAB);
        rd_chk(8'h76, 8'hCD);
        src.line(0, 16'h2222);
        rd_chk(8'h75, 8'h22);
    endtask
    // Hysteresis 3, stable code 10, low limit 5
    task automatic t_freq;
        wr(8'h4C, 8'h02);
        wr(8'h77, 8'hE5);
        src.freq(2, 8'h03);
        `CHK(nclk[2], 1'b1)
        `CHK(capt[23:16], 8'h00)
        src.freq(2, 8'h0A);
        `CHK({nclk[2], capt[23:16]}, 9'h00A)
        src.freq(2, 8'h0D);
        `CHK(capt[23:16], 8'h0A)
        src.freq(2, 8'h0E);
        `CHK(capt[23:16], 8'h0E)
        repeat (10) src.freq(2, 8'h0E);
        `CHK(stable[2], 1'b0)
        repeat (12) src.freq(2, 8'h0E);
        `CHK(stable[2], 1'b1)
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_scratch();
        t_errors();
        t_line();
        t_freq();
        tally_and_finish();
    end
    // Watchdog, far beyond the roughly 170 cycles of the scenarios
    initial begin
        #(20 * 20000);
        error_cnt++;
        tally_and_finish();
    end
endmodule // rx_port_monitor_regs_tb
